// File: inc/glfm_map.vh
// Function
// - power-to-unlock build: magnet input high releases the solenoid, low locks it
// - power-to-lock build: magnet input high engages the lock, low releases it
// - standard build: unlock disables both safety outputs; relock re-enables without opening
// - door-monitoring build: safety outputs drop only when the guard opens
// - drive green supply lamp, yellow operating lamp, red fault flash-code lamp
// - internal error disables outputs; clears after cause gone and guard opened/closed
// - multiple output faults or output short latch a lockout cleared only by power
// - fault warning drops diagnostic output, keeps safety outputs, self-clears when gone
// - warning persisting 30 minutes also shuts safety outputs and flashes red
// - output A fault (test fail or voltage while off): one flash, 30 min shutdown
// - output B fault (test fail or voltage while off): two flashes, 30 min shutdown
// - output short or both outputs faulted: three flashes, warning, immediate lockout
// - over-temperature: four flashes, warning, 30 min shutdown
// - wrong or defective actuator: five flashes, immediate shutdown
// - invalid actuator combination or tamper: six flashes, immediate shutdown
// - internal defect or supply out of range: steady red, immediate shutdown
`ifndef GLFM_MAP_VH
`define GLFM_MAP_VH

// ============================================================
// clock and timing
`define GLFM_CLK_HZ       250000000
`define GLFM_WARN_MIN     30
`define GLFM_SEC_PER_MIN  60
`define GLFM_TICK_US      1000
`define GLFM_US_PER_SEC   1000000
`define GLFM_FLASH_ON_MS  200
`define GLFM_FLASH_OFF_MS 300
`define GLFM_PAUSE_MS     1500
`define GLFM_YEL_HALF_MS  500

// ============================================================
// register offsets
`define GLFM_REG_CTRL     8'h00
`define GLFM_REG_STATUS   8'h04
`define GLFM_REG_IRQ_STAT 8'h08
`define GLFM_REG_IRQ_MASK 8'h0c

// ============================================================
// control fields and reset values
`define GLFM_CTRL_PTL     0
`define GLFM_CTRL_DOORMON 1
`define GLFM_CTRL_RST     2'h0
`define GLFM_MASK_RST     5'h00

// ============================================================
// interrupt bits
`define GLFM_IRQ_WARN     0
`define GLFM_IRQ_ERR      1
`define GLFM_IRQ_LOCKOUT  2
`define GLFM_IRQ_EXPIRED  3
`define GLFM_IRQ_LOCKCHG  4
`define GLFM_IRQ_W        5

// ============================================================
// flash codes
`define GLFM_CODE_NONE    4'h0
`define GLFM_CODE_OUT_A   4'h1
`define GLFM_CODE_OUT_B   4'h2
`define GLFM_CODE_SHORT   4'h3
`define GLFM_CODE_TEMP    4'h4
`define GLFM_CODE_ACT     4'h5
`define GLFM_CODE_COMBO   4'h6
`define GLFM_CODE_STEADY  4'hf

`endif

// File: core/glfm_flash.v
`timescale 1ns/100ps
`include "glfm_map.vh"

module glfm_flash #(
  parameter ON_TICKS    = `GLFM_FLASH_ON_MS,
  parameter OFF_TICKS   = `GLFM_FLASH_OFF_MS,
  parameter PAUSE_TICKS = `GLFM_PAUSE_MS
) (
  input  wire       clk,     // system clock
  input  wire       rst_n,   // synchronised reset, active low
  input  wire       tick,    // slow time base enable
  input  wire [3:0] code,    // pulses per group, none or steady
  output reg        lamp     // red lamp drive
);

  localparam [3:0] S_IDLE  = 4'h1;
  localparam [3:0] S_ON    = 4'h2;
  localparam [3:0] S_OFF   = 4'h4;
  localparam [3:0] S_PAUSE = 4'h8;

  reg [3:0]  state;
  reg [15:0] cnt;
  reg [3:0]  pulses;

  // ============================================================
  // pulse group sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state  <= S_IDLE;
      cnt    <= 16'h0000;
      pulses <= 4'h0;
      lamp   <= 1'b0;
    end else if (code == `GLFM_CODE_STEADY) begin
      state <= S_IDLE;
      lamp  <= 1'b1;
    end else if (code == `GLFM_CODE_NONE) begin
      state <= S_IDLE;
      lamp  <= 1'b0;
    end else if (tick) begin
      case (state)
        S_IDLE: begin
          state  <= S_ON;
          cnt    <= 16'h0000;
          pulses <= 4'h1;
          lamp   <= 1'b1;
        end
        S_ON: begin
          if (cnt == ON_TICKS[15:0] - 16'h0001) begin
            cnt  <= 16'h0000;
            lamp <= 1'b0;
            // code is resampled at every pulse so a changed fault shows quickly
            state <= (pulses >= code) ? S_PAUSE : S_OFF;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        S_OFF: begin
          if (cnt == OFF_TICKS[15:0] - 16'h0001) begin
            cnt    <= 16'h0000;
            pulses <= pulses + 4'h1;
            lamp   <= 1'b1;
            state  <= S_ON;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        S_PAUSE: begin
          if (cnt == PAUSE_TICKS[15:0] - 16'h0001) begin
            state <= S_IDLE;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        default: begin
          state <= S_IDLE;
          lamp  <= 1'b0;
        end
      endcase
    end
  end

endmodule // glfm_flash

// File: core/glfm_top.v
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "glfm_map.vh"

module glfm_top #(
  parameter [39:0] WARN_CYCLES = 40'd`GLFM_WARN_MIN * 40'd`GLFM_SEC_PER_MIN
                                 * 40'd`GLFM_CLK_HZ,
  parameter        TICK_CYCLES = (`GLFM_CLK_HZ / `GLFM_US_PER_SEC) * `GLFM_TICK_US
) (
  input  wire        I_CLK,          // system clock, 250 MHz
  input  wire        I_NRST,         // power-on reset, active low
  input  wire [7:0]  I_ADDR,         // register byte address
  input  wire [31:0] I_WDATA,        // register write data
  input  wire        I_WR,           // write strobe
  input  wire        I_RD,           // read strobe
  input  wire        I_MAGNET,       // magnet control input, high = 24 V
  input  wire        I_DOOR_CLOSED,  // guard closed
  input  wire        I_ACT_IN,       // actuator inserted
  input  wire        I_FB_A,         // voltage seen on safety_output_a
  input  wire        I_FB_B,         // voltage seen on safety_output_b
  input  wire        I_TEST_FAIL_A,  // output test of safety_output_a failed
  input  wire        I_TEST_FAIL_B,  // output test of safety_output_b failed
  input  wire        I_SHORT_AB,     // short between the two outputs
  input  wire        I_OVERTEMP,     // internal temperature too high
  input  wire        I_BAD_ACT,      // wrong or defective actuator
  input  wire        I_ACT_COMBO,    // invalid actuator combination / tamper
  input  wire        I_INT_DEFECT,   // internal device defect
  input  wire        I_SUPPLY_BAD,   // supply out of range
  output reg  [31:0] O_RDATA,        // read data, cycle after read strobe
  output reg         O_SOLENOID,     // solenoid lock engaged
  output reg         O_SAFETY_A,     // safety_output_a
  output reg         O_SAFETY_B,     // safety_output_b
  output reg         O_DIAG,         // non-safety diagnostic output
  output reg         O_LED_GREEN,    // supply lamp
  output reg         O_LED_YELLOW,   // status lamp
  output reg         O_LED_RED,      // fault lamp
  output reg         O_IRQ           // level interrupt
);

  localparam [15:0] YEL_TICKS = `GLFM_YEL_HALF_MS;

  // ============================================================
  // reset release
  // reset takes hold at once, but lets go only on a clock edge, two flops deep
  reg rst_meta;
  reg rst_n;

  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ============================================================
  // slow time base: tick enable and yellow blink phase
  // a one millisecond enable keeps the lamp counters narrow; the warning timer
  // counts raw clocks so that its end point is exact
  reg [31:0] div_cnt;
  reg        tick;
  reg [15:0] yel_cnt;
  reg        yel_phase;

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= 32'h0000_0000;
      tick      <= 1'b0;
      yel_cnt   <= 16'h0000;
      yel_phase <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (div_cnt == TICK_CYCLES[31:0] - 32'h0000_0001) begin
        div_cnt <= 32'h0000_0000;
        tick    <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 32'h0000_0001;
      end
      if (tick) begin
        if (yel_cnt == YEL_TICKS - 16'h0001) begin
          yel_cnt   <= 16'h0000;
          yel_phase <= ~yel_phase;
        end else begin
          yel_cnt <= yel_cnt + 16'h0001;
        end
      end
    end
  end

  // ============================================================
  // control register
  reg [1:0] ctrl;
  wire      ptl     = ctrl[`GLFM_CTRL_PTL];
  wire      doormon = ctrl[`GLFM_CTRL_DOORMON];

  // ============================================================
  // lock state
  // the wiring bit picks which magnet level means locked; the guard only counts
  // as locked with the door shut and the actuator inside
  wire lock_cmd = ptl ? I_MAGNET : ~I_MAGNET;
  wire locked   = lock_cmd & I_ACT_IN & I_DOOR_CLOSED;
  wire inserted = I_ACT_IN & I_DOOR_CLOSED;

  // ============================================================
  // fault classification
  localparam NCH = 2;

  wire [NCH-1:0] ch_on   = {O_SAFETY_B, O_SAFETY_A};
  wire [NCH-1:0] ch_fb   = {I_FB_B, I_FB_A};
  wire [NCH-1:0] ch_test = {I_TEST_FAIL_B, I_TEST_FAIL_A};
  wire [NCH-1:0] ch_fault;

  // readback voltage only means a fault while that channel is switched off:
  // an outside source is then feeding the line
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      assign ch_fault[ch] = ch_test[ch] | (ch_fb[ch] & ~ch_on[ch]);
    end
  endgenerate

  wire fault_a   = ch_fault[0];
  wire fault_b   = ch_fault[1];
  wire fault_two = (fault_a & fault_b) | I_SHORT_AB;
  wire warning   = fault_a | fault_b | I_SHORT_AB | I_OVERTEMP;
  wire hard_now  = I_BAD_ACT | I_ACT_COMBO | I_INT_DEFECT | I_SUPPLY_BAD;

  reg [3:0] warn_code;
  always @* begin
    if (fault_two) begin
      warn_code = `GLFM_CODE_SHORT;
    end else if (fault_a) begin
      warn_code = `GLFM_CODE_OUT_A;
    end else if (fault_b) begin
      warn_code = `GLFM_CODE_OUT_B;
    end else if (I_OVERTEMP) begin
      warn_code = `GLFM_CODE_TEMP;
    end else begin
      warn_code = `GLFM_CODE_NONE;
    end
  end

  reg [3:0] hard_code;
  always @* begin
    if (I_INT_DEFECT | I_SUPPLY_BAD) begin
      hard_code = `GLFM_CODE_STEADY;
    end else if (I_ACT_COMBO) begin
      hard_code = `GLFM_CODE_COMBO;
    end else if (I_BAD_ACT) begin
      hard_code = `GLFM_CODE_ACT;
    end else begin
      hard_code = `GLFM_CODE_NONE;
    end
  end

  // ============================================================
  // fault state: warning timer, error latch, lockout
  reg [39:0] warn_cnt;
  reg        expired;
  reg        err;
  reg [3:0]  err_code;
  reg        err_opened;
  reg        lockout;
  reg        seen_a;
  reg        seen_b;

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      warn_cnt   <= 40'h00_0000_0000;
      expired    <= 1'b0;
      err        <= 1'b0;
      err_code   <= `GLFM_CODE_NONE;
      err_opened <= 1'b0;
      lockout    <= 1'b0;
      seen_a     <= 1'b0;
      seen_b     <= 1'b0;
    end else begin
      // a warning that goes away restarts the timer and releases the outputs
      if (!warning) begin
        warn_cnt <= 40'h00_0000_0000;
        expired  <= 1'b0;
      end else if (warn_cnt == WARN_CYCLES - 40'h00_0000_0001) begin
        expired <= 1'b1;
      end else begin
        warn_cnt <= warn_cnt + 40'h00_0000_0001;
      end
      if (fault_a) begin
        seen_a <= 1'b1;
      end
      if (fault_b) begin
        seen_b <= 1'b1;
      end
      // history of both outputs kept so separate faults still add up; only reset clears it
      if (fault_two | (seen_a & fault_b) | (seen_b & fault_a)) begin
        lockout <= 1'b1;
      end
      // an opening only counts once the cause has gone, so the guard must be
      // opened and closed after the repair
      if (hard_now) begin
        err        <= 1'b1;
        err_code   <= hard_code;
        err_opened <= 1'b0;
      end else if (err) begin
        if (!I_DOOR_CLOSED) begin
          err_opened <= 1'b1;
        end else if (err_opened) begin
          err        <= 1'b0;
          err_code   <= `GLFM_CODE_NONE;
          err_opened <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // output gating
  wire base_en   = doormon ? inserted : locked;
  wire safety_en = base_en & ~err & ~lockout & ~expired;

  reg [3:0] red_code;
  always @* begin
    if (err) begin
      red_code = err_code;
    end else if (lockout) begin
      // a lockout stems from an output short or from faults on both outputs, so it shows that code
      red_code = `GLFM_CODE_SHORT;
    end else begin
      red_code = warn_code;
    end
  end

  wire red_lamp;

  glfm_flash u_flash (
    .clk   (I_CLK),
    .rst_n (rst_n),
    .tick  (tick),
    .code  (red_code),
    .lamp  (red_lamp)
  );

  // steady while locked, blinking while inserted but free
  wire next_yel = (err | lockout) ? 1'b0 :
                  locked          ? 1'b1 :
                  inserted        ? yel_phase : 1'b0;

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_SOLENOID   <= 1'b0;
      O_SAFETY_A   <= 1'b0;
      O_SAFETY_B   <= 1'b0;
      O_DIAG       <= 1'b0;
      O_LED_GREEN  <= 1'b0;
      O_LED_YELLOW <= 1'b0;
      O_LED_RED    <= 1'b0;
    end else begin
      // lockout holds the guard locked electronically whatever the magnet input says
      O_SOLENOID   <= lock_cmd | lockout;
      O_SAFETY_A   <= safety_en;
      O_SAFETY_B   <= safety_en;
      // the diagnostic output drops on any warning so the machine can stop in an
      // orderly way before the safety outputs follow
      O_DIAG       <= safety_en & ~warning;
      O_LED_GREEN  <= 1'b1;
      O_LED_YELLOW <= next_yel;
      O_LED_RED    <= red_lamp;
    end
  end

  // ============================================================
  // interrupt status
  reg [`GLFM_IRQ_W-1:0] irq_stat;
  reg [`GLFM_IRQ_W-1:0] irq_mask;
  reg                   warn_d;
  reg                   err_d;
  reg                   lockout_d;
  reg                   expired_d;
  reg                   locked_d;

  // each event is a rising edge of its source, except the lock state, which counts both ways
  wire [`GLFM_IRQ_W-1:0] irq_set = {locked ^ locked_d,
                                    expired & ~expired_d,
                                    lockout & ~lockout_d,
                                    err & ~err_d,
                                    warning & ~warn_d};

  wire wr_irq_stat = I_WR & (I_ADDR == `GLFM_REG_IRQ_STAT);

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat  <= {`GLFM_IRQ_W{1'b0}};
      warn_d    <= 1'b0;
      err_d     <= 1'b0;
      lockout_d <= 1'b0;
      expired_d <= 1'b0;
      locked_d  <= 1'b0;
      O_IRQ     <= 1'b0;
    end else begin
      warn_d    <= warning;
      err_d     <= err;
      lockout_d <= lockout;
      expired_d <= expired;
      locked_d  <= locked;
      // set wins over a write-one clear in the same cycle
      irq_stat  <= (irq_stat & ~(wr_irq_stat ? I_WDATA[`GLFM_IRQ_W-1:0]
                                             : {`GLFM_IRQ_W{1'b0}})) | irq_set;
      O_IRQ     <= |(irq_stat & irq_mask);
    end
  end

  // ============================================================
  // register port
  // from bit 0 up: door, actuator, locked, enable, warning, error, expired, lockout, code
  wire [31:0] status_word = {20'h0_0000, red_code, lockout, expired, err, warning,
                             safety_en, locked, I_ACT_IN, I_DOOR_CLOSED};

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= `GLFM_CTRL_RST;
      irq_mask <= `GLFM_MASK_RST;
      O_RDATA  <= 32'h0000_0000;
    end else begin
      if (I_WR) begin
        case (I_ADDR)
          `GLFM_REG_CTRL: begin
            ctrl[`GLFM_CTRL_PTL]     <= I_WDATA[`GLFM_CTRL_PTL];
            ctrl[`GLFM_CTRL_DOORMON] <= I_WDATA[`GLFM_CTRL_DOORMON];
          end
          `GLFM_REG_IRQ_MASK: begin
            irq_mask <= I_WDATA[`GLFM_IRQ_W-1:0];
          end
          default: begin
            ctrl <= ctrl;
          end
        endcase
      end
      O_RDATA <= 32'h0000_0000;
      if (I_RD) begin
        case (I_ADDR)
          `GLFM_REG_CTRL:     O_RDATA <= {30'h0000_0000, ctrl};
          `GLFM_REG_STATUS:   O_RDATA <= status_word;
          `GLFM_REG_IRQ_STAT: O_RDATA <= {27'h000_0000, irq_stat};
          `GLFM_REG_IRQ_MASK: O_RDATA <= {27'h000_0000, irq_mask};
          default:            O_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // glfm_top

// File: test/glfm_properties.sv
`timescale 1ns/100ps
`include "glfm_map.vh"
// ============================================================
// port-level checks of the lock supervisor
module glfm_chk #(
  parameter [39:0] WARN_CYCLES = 40'd200
) (
  input wire       I_CLK,         // clock
  input wire       I_NRST,        // reset
  input wire [7:0] I_ADDR,        // address
  input wire [31:0] I_WDATA,      // write data
  input wire       I_WR,          // write strobe
  input wire       I_MAGNET,      // magnet line
  input wire       I_DOOR_CLOSED, // guard closed
  input wire       I_OVERTEMP,    // hot
  input wire       I_BAD_ACT,     // bad actuator
  input wire       I_ACT_COMBO,   // tamper
  input wire       I_INT_DEFECT,  // defect
  input wire       I_SUPPLY_BAD,  // supply fault
  input wire       O_SOLENOID,    // lock
  input wire       O_SAFETY_A,    // output a
  input wire       O_SAFETY_B,    // output b
  input wire       O_DIAG,        // diagnostic
  input wire       O_LED_GREEN,   // green
  input wire       O_LED_YELLOW,  // yellow
  input wire       O_LED_RED      // red
);
  // ============================================================
  // mirror of the wiring bits, and run counters
  reg        ptl;
  reg        dmon;
  reg [1:0]  rcnt;
  reg [39:0] wcnt;
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ptl <= 1'b0;
      dmon <= 1'b0;
      rcnt <= 2'h0;
      wcnt <= 40'h0;
    end else begin
      if (I_WR && I_ADDR == `GLFM_REG_CTRL) begin
        ptl <= I_WDATA[0];
        dmon <= I_WDATA[1];
      end
      if (rcnt != 2'h3) rcnt <= rcnt + 2'h1;
      wcnt <= I_OVERTEMP ? wcnt + 40'h1 : 40'h0;
    end
  end
  // ============================================================
  // properties
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  pair_equal_a: assert property (O_SAFETY_A == O_SAFETY_B)
    else $error("safety outputs differ");
  ptu_release_a: assert property (!ptl && I_MAGNET |=> !O_SOLENOID)
    else $error("lock held with magnet high");
  ptl_release_a: assert property (ptl && !I_MAGNET |=> !O_SOLENOID)
    else $error("lock held with magnet low");
  std_gate_a: assert property (O_SAFETY_A && !$past(dmon) |-> O_SOLENOID)
    else $error("safety on while unlocked");
  door_open_a: assert property (!I_DOOR_CLOSED |=>
    !O_SAFETY_A && !O_DIAG && !O_LED_YELLOW)
    else $error("outputs on with guard open");
  locked_yel_a: assert property (O_SOLENOID && O_SAFETY_A |-> O_LED_YELLOW)
    else $error("yellow off while locked");
  diag_safe_a: assert property (O_DIAG |-> O_SAFETY_A)
    else $error("diag on without safety");
  warn_diag_a: assert property (I_OVERTEMP |=> !O_DIAG)
    else $error("diag on during warning");
  err_off_a: assert property ((I_BAD_ACT || I_ACT_COMBO ||
    I_INT_DEFECT || I_SUPPLY_BAD) |-> ##2 !O_SAFETY_A)
    else $error("safety on after error");
  steady_red_a: assert property (I_INT_DEFECT [*8] |=> O_LED_RED)
    else $error("red not steady on defect");
  green_on_a: assert property (rcnt == 2'h3 |-> O_LED_GREEN)
    else $error("green lamp off");
  warn_expiry_a: assert property (wcnt > WARN_CYCLES + 40'd4 |-> !O_SAFETY_A)
    else $error("safety on after warning expiry");
endmodule // glfm_chk

bind glfm_top glfm_chk #(.WARN_CYCLES(WARN_CYCLES)) chk_u (.*);

// File: test/glfm_plc.sv
`timescale 1ns/100ps
// ============================================================
// machine controller driving the magnet line
module glfm_plc (
  input  wire  clk,       // system clock
  input  wire  ptl,       // wiring, 1 = power-to-lock
  input  wire  want_lock, // controller wants the guard locked
  input  wire  slow,      // answer six cycles late instead of one
  output logic magnet     // magnet control, high = 24 V
);
  logic [5:0] pipe = 6'h3f;
  always @(posedge clk) begin
    pipe <= {pipe[4:0], ptl ? want_lock : ~want_lock};
  end
  assign magnet = slow ? pipe[5] : pipe[0];
endmodule // glfm_plc

// File: test/tb.sv
`timescale 1ns/100ps
`include "glfm_map.vh"
module tb;
  localparam [39:0] WARN = 40'd200;
  localparam [7:0]  ST = `GLFM_REG_STATUS;
  localparam [7:0]  MK = `GLFM_REG_IRQ_MASK;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        door = 1'b0;
  logic        act = 1'b0;
  logic        ptl = 1'b0;
  logic        want = 1'b0;
  logic        slow = 1'b0;
  logic [9:0]  flt = 10'h000;
  logic [31:0] rdata;
  logic        magnet, sol, sa, sb, diag, lg, ly, lr, irq;
  int          num_errors = 0;
  int          total_checks = 0;

  glfm_top #(.WARN_CYCLES(WARN), .TICK_CYCLES(4)) dut_u (
    .I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_MAGNET(magnet), .I_DOOR_CLOSED(door), .I_ACT_IN(act),
    .I_FB_A(flt[0]), .I_FB_B(flt[1]), .I_TEST_FAIL_A(flt[2]), .I_TEST_FAIL_B(flt[3]),
    .I_SHORT_AB(flt[4]), .I_OVERTEMP(flt[5]), .I_BAD_ACT(flt[6]), .I_ACT_COMBO(flt[7]),
    .I_INT_DEFECT(flt[8]), .I_SUPPLY_BAD(flt[9]), .O_RDATA(rdata), .O_SOLENOID(sol),
    .O_SAFETY_A(sa), .O_SAFETY_B(sb), .O_DIAG(diag), .O_LED_GREEN(lg),
    .O_LED_YELLOW(ly), .O_LED_RED(lr), .O_IRQ(irq));
  glfm_plc plc_u (.clk(clk), .ptl(ptl), .want_lock(want), .slow(slow), .magnet(magnet));

  initial begin
    forever #2 clk = ~clk;
  end
  // ============================================================
  // shared tasks
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata & m);
  endtask
  // a group starts after a low run longer than any gap inside it
  task automatic count_flash(input int e);
    int n = 0;
    int lo = 0;
    bit st = 0;
    for (int i = 0; i < 45000; i++) begin
      tick(1);
      if (lr === 1'b1) begin
        if (lo >= 2000) begin
          if (st) break;
          st = 1;
        end
        if (lo > 0 && st) n++;
        lo = 0;
      end else lo++;
      if (i == 44999) begin
        num_errors++;
        report_and_stop();
      end
    end
    chk("flash count", e, n);
  endtask
  // ============================================================
  // scenarios
  task automatic t_regs();
    rchk("ctrl reset", `GLFM_REG_CTRL, 32'hffffffff, 32'h0);
    rchk("mask reset", MK, 32'hffffffff, 32'h0);
    wr_reg(8'h40, 32'h3);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
    wr_reg(`GLFM_REG_CTRL, 32'h3);
    rchk("ctrl rw", `GLFM_REG_CTRL, 32'hffffffff, 32'h3);
    wr_reg(`GLFM_REG_CTRL, 32'h0);
    chk("green", 1, lg);
  endtask
  task automatic t_lock();
    int   flips = 0;
    logic ly_prev;
    @(posedge clk) door <= 1'b1;
    act <= 1'b1;
    want <= 1'b1;
    slow <= 1'b1;
    tick(10);
    chk("locked outs", 4'hf, {sol, sa, sb, diag});
    chk("yellow steady", 1, ly);
    @(posedge clk) want <= 1'b0;
    tick(10);
    chk("unlocked outs", 4'h0, {sol, sa, sb, diag});
    ly_prev = ly;
    repeat (2100) begin
      tick(1);
      if (ly !== ly_prev) flips++;
      ly_prev = ly;
    end
    chk("yellow blinks", 1, flips != 0);
    @(posedge clk) want <= 1'b1;
    tick(10);
    chk("relocked", 2'h3, {sa, sb});
  endtask
  task automatic t_modes();
    wr_reg(`GLFM_REG_CTRL, 32'h1);
    ptl <= 1'b1;
    slow <= 1'b0;
    tick(4);
    chk("ptl lock", 2'h3, {magnet, sol});
    @(posedge clk) want <= 1'b0;
    tick(4);
    chk("ptl release", 0, sol);
    wr_reg(`GLFM_REG_CTRL, 32'h2);
    ptl <= 1'b0;
    tick(4);
    chk("dmon unlocked", 3'h3, {sol, sa, sb});
    @(posedge clk) door <= 1'b0;
    tick(3);
    chk("dmon open", 4'h0, {sa, sb, diag, ly});
    @(posedge clk) door <= 1'b1;
    want <= 1'b1;
    wr_reg(`GLFM_REG_CTRL, 32'h0);
    tick(4);
  endtask
  task automatic t_warn();
    wr_reg(MK, 32'h1);
    flt[5] <= 1'b1;
    tick(3);
    chk("warn outs", 4'hd, {sa, sb, diag, irq});
    wr_reg(MK, 32'h0);
    tick(2);
    chk("irq masked", 0, irq);
    count_flash(4);
    chk("expired", 2'h0, {sa, sb});
    rchk("expired flag", ST, 32'h50, 32'h50);
    @(posedge clk) flt[5] <= 1'b0;
    tick(3);
    chk("warn gone", 3'h7, {sa, sb, diag});
    wr_reg(`GLFM_REG_IRQ_STAT, 32'h1f);
    wr_reg(MK, 32'h1f);
    tick(3);
    chk("irq cleared", 0, irq);
  endtask
  task automatic t_err();
    logic [3:0] code [4] = '{4'h5, 4'h6, 4'hf, 4'hf};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) flt[6 + i] <= 1'b1;
      tick(10);
      chk("err safety", 2'h0, {sa, sb});
      rchk("err code", ST, 32'hf20, {20'h0, code[i], 8'h20});
      @(posedge clk) flt[6 + i] <= 1'b0;
      tick(3);
      rchk("err held", ST, 32'h28, 32'h20);
      @(posedge clk) door <= 1'b0;
      tick(3);
      @(posedge clk) door <= 1'b1;
      tick(4);
      rchk("err cleared", ST, 32'h28, 32'h08);
    end
  endtask
  task automatic t_fault();
    @(posedge clk) want <= 1'b0;
    tick(4);
    @(posedge clk) flt[0] <= 1'b1;
    tick(4);
    rchk("out a code", ST, 32'hf10, 32'h110);
    @(posedge clk) flt[0] <= 1'b0;
    want <= 1'b1;
    tick(4);
    @(posedge clk) flt[3] <= 1'b1;
    tick(4);
    @(posedge clk) flt[3] <= 1'b0;
    tick(4);
    rchk("lockout", ST, 32'hf88, 32'h380);
    chk("lockout outs", 3'h4, {sol, sa, sb});
    @(posedge clk) nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    tick(10);
    chk("after power", 2'h3, {sa, sb});
    @(posedge clk) flt[3] <= 1'b1;
    count_flash(2);
    @(posedge clk) flt[3] <= 1'b0;
    flt[4] <= 1'b1;
    tick(4);
    rchk("short", ST, 32'hf80, 32'h380);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    tick(4);
    t_regs();
    t_lock();
    t_modes();
    t_warn();
    t_err();
    t_fault();
    report_and_stop();
  end
endmodule // tb
